// ==== verilog/ilo_decode_params.svh ====
/*
 * Constants for the indexed literal-offset operand decoder: register map,
 * field positions, opcode patterns and reset values.
 * Assumes inclusion by bare name from the decoder module.
 */
`ifndef ILO_DECODE_PARAMS_SVH
`define ILO_DECODE_PARAMS_SVH

// register byte addresses on the wishbone slave
`define REG_CTRL_ADDR       8'h00
`define REG_FRAME_ADDR      8'h04
`define REG_BANK_ADDR       8'h08
`define REG_ACC_ADDR        8'h0c
`define REG_OPCODE_ADDR     8'h10
`define REG_STATUS_ADDR     8'h14
`define REG_RESULT_ADDR     8'h18
`define REG_DATA_ADDR       8'h1c

// operand field layout of a 16-bit opcode
`define OP_ACCESS_BIT       8
`define OP_DEST_BIT         9
`define OP_BITSEL_LSB       9
`define OP_FILE_MSB         7
`define INDEX_LIMIT         8'h5f
`define ACCESS_SPLIT        8'h60
`define ACCESS_HIGH_BANK    4'hf

// opcode patterns
`define OPC_ADD_HI          6'h09
`define OPC_BSET_HI         4'h8

// reset values
`define CTRL_RESET          1'h0
`define FRAME_RESET         12'h000
`define BANK_RESET          4'h0
`define ACC_RESET           8'h00
`define OPCODE_RESET        16'h0000

// status flag positions: n ov z dc c
`define FLAG_C              0
`define FLAG_DC             1
`define FLAG_Z              2
`define FLAG_OV             3
`define FLAG_N              4

`endif

// ==== verilog/ilo_decode_pkg.sv ====
/*
 * Types shared by the indexed literal-offset operand decoder.
 * Assumes the params header is on the include path.
 */
package ilo_decode_pkg;

   // decoded operand address with how it was formed
   typedef struct packed {
      logic [11:0] addr;
      logic        indexed;
   } operand_addr_type;

   // whole state of the decoder
   typedef struct packed {
      logic        ext_en;
      logic [11:0] frame;
      logic [3:0]  bank;
      logic [7:0]  acc;
      logic [15:0] opcode;
      logic [4:0]  flags;
      logic [11:0] last_addr;
      logic        last_indexed;
      logic [7:0]  result;
      logic [7:0]  data_wr;
      logic        data_we;
      logic [31:0] dat;
      logic        ack;
      logic        busy;
   } state_type;

endpackage

// ==== verilog/ilo_decode.sv ====
/*
 * Indexed literal-offset operand decoder with a small execution slice:
 * decodes the file operand of any byte or bit instruction, and executes the
 * indexed add and indexed bit set forms against a data-memory port.
 * Assumes a classic wishbone master, and a data memory that answers a read
 * combinationally and writes at the clock edge on data_we_o.
 */
`timescale 1ns/1ps
`include "ilo_decode_params.svh"

module ilo_decode
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // data memory port
   output logic      [11:0] data_addr_o,
   output logic             data_indexed_o,
   input  wire logic [7:0]  data_rd_i,
   output logic      [7:0]  data_wr_o,
   output logic             data_we_o,
   // configuration seen by the core
   output logic             ext_en_o
);

   ilo_decode_pkg::state_type        s_q;
   ilo_decode_pkg::state_type        s_d;
   ilo_decode_pkg::operand_addr_type op_addr;
   logic [7:0]  file_f;
   logic        access_a;
   logic [8:0]  sum9;
   logic [4:0]  low5;
   logic [7:0]  add_res;
   logic [7:0]  bit_res;
   logic [2:0]  bit_sel;
   logic        is_add;
   logic        is_bset;
   logic        acc_hit;
   logic [31:0] rd_mux;

   // operand address decode for whatever opcode is loaded
   always_comb
   begin
      file_f   = s_q.opcode[`OP_FILE_MSB:0];
      access_a = s_q.opcode[`OP_ACCESS_BIT];
      op_addr  = '0;
      if (s_q.ext_en && !access_a && (file_f <= `INDEX_LIMIT))
      begin
         // frame 000h maps offsets onto access low range
         op_addr.addr    = s_q.frame + {4'h0, file_f};
         op_addr.indexed = 1'b1;
      end
      else if (access_a)
      begin
         op_addr.addr = {s_q.bank, file_f};
      end
      else
      begin
         // access bank: low part of bank 0, upper part of the top bank
         op_addr.addr = (file_f < `ACCESS_SPLIT) ? {4'h0, file_f}
                                                 : {`ACCESS_HIGH_BANK, file_f};
      end
   end

   // arithmetic for the add and bit-set forms
   always_comb
   begin
      sum9    = {1'b0, s_q.acc} + {1'b0, data_rd_i};
      low5    = {1'b0, s_q.acc[3:0]} + {1'b0, data_rd_i[3:0]};
      add_res = sum9[7:0];
      bit_sel = s_q.opcode[`OP_BITSEL_LSB+2:`OP_BITSEL_LSB];
      bit_res = data_rd_i | (8'h01 << bit_sel);
      // the mode checks decode both forms regardless of extension
      is_add  = (s_q.opcode[15:10] == `OPC_ADD_HI);
      is_bset = (s_q.opcode[15:12] == `OPC_BSET_HI);
   end

   // register read mux
   always_comb
   begin
      acc_hit = 1'b1;
      rd_mux  = 32'h0000_0000;
      unique case (adr_i)
         `REG_CTRL_ADDR:   rd_mux = {31'h0, s_q.ext_en};
         `REG_FRAME_ADDR:  rd_mux = {20'h0, s_q.frame};
         `REG_BANK_ADDR:   rd_mux = {28'h0, s_q.bank};
         `REG_ACC_ADDR:    rd_mux = {24'h0, s_q.acc};
         `REG_OPCODE_ADDR: rd_mux = {16'h0, s_q.opcode};
         `REG_STATUS_ADDR: rd_mux = {27'h0, s_q.flags};
         `REG_RESULT_ADDR: rd_mux = {19'h0, s_q.last_indexed, s_q.last_addr};
         `REG_DATA_ADDR:   rd_mux = {24'h0, s_q.result};
         default:          acc_hit = 1'b0;
      endcase
   end

   // next state: bus slave, execution, memory write strobe
   always_comb
   begin
      s_d         = s_q;
      s_d.data_we = 1'b0;
      s_d.ack     = 1'b0;
      s_d.busy    = 1'b0;
      // one answer per request; unmapped reads give zero
      if (cyc_i && stb_i && !s_q.ack && !s_q.busy)
      begin
         s_d.ack = 1'b1;
         s_d.dat = acc_hit ? rd_mux : 32'h0000_0000;
         if (we_i && acc_hit)
         begin
            unique case (adr_i)
               `REG_CTRL_ADDR:
                  if (sel_i[0])
                     s_d.ext_en = dat_i[0];
               `REG_FRAME_ADDR:
               begin
                  if (sel_i[0])
                     s_d.frame[7:0] = dat_i[7:0];
                  if (sel_i[1])
                     s_d.frame[11:8] = dat_i[11:8];
               end
               `REG_BANK_ADDR:
                  if (sel_i[0])
                     s_d.bank = dat_i[3:0];
               `REG_ACC_ADDR:
                  if (sel_i[0])
                     s_d.acc = dat_i[7:0];
               `REG_OPCODE_ADDR:
               begin
                  if (sel_i[0])
                     s_d.opcode[7:0] = dat_i[7:0];
                  if (sel_i[1])
                     s_d.opcode[15:8] = dat_i[15:8];
               end
               `REG_STATUS_ADDR:
                  if (sel_i[0])
                     s_d.flags = dat_i[4:0];
               `REG_RESULT_ADDR:
               begin
                  // write here executes the loaded opcode in one cycle
                  s_d.last_addr    = op_addr.addr;
                  s_d.last_indexed = op_addr.indexed;
                  s_d.busy         = 1'b1;
                  if (is_add)
                  begin
                     s_d.result            = add_res;
                     s_d.flags[`FLAG_C]    = sum9[8];
                     s_d.flags[`FLAG_DC]   = low5[4];
                     s_d.flags[`FLAG_Z]    = (add_res == 8'h00);
                     s_d.flags[`FLAG_N]    = add_res[7];
                     s_d.flags[`FLAG_OV]   = (s_q.acc[7] == data_rd_i[7])
                                             && (add_res[7] != s_q.acc[7]);
                     if (s_q.opcode[`OP_DEST_BIT])
                     begin
                        s_d.data_wr = add_res;
                        s_d.data_we = 1'b1;
                     end
                     else
                        s_d.acc = add_res;
                  end
                  else if (is_bset)
                  begin
                     s_d.result  = bit_res;                  // flags kept
                     s_d.data_wr = bit_res;
                     s_d.data_we = 1'b1;
                  end
                  else
                     s_d.result = data_rd_i;
               end
               default:
                  s_d.result = s_q.result;
            endcase
         end
      end
      if (rst_i)
      begin
         s_d        = '0;
         s_d.ext_en = `CTRL_RESET;
         s_d.frame  = `FRAME_RESET;
         s_d.bank   = `BANK_RESET;
         s_d.acc    = `ACC_RESET;
         s_d.opcode = `OPCODE_RESET;
      end
   end

   // all state in one register; reset folded in above
   always_ff @(posedge clk_i)
   begin
      s_q <= s_d;
   end

   // outputs from flops except the decoded operand address; write address latched with its data
   assign dat_o          = s_q.dat;
   assign ack_o          = s_q.ack;
   assign data_addr_o    = s_q.data_we ? s_q.last_addr : op_addr.addr;
   assign data_indexed_o = s_q.data_we ? s_q.last_indexed : op_addr.indexed;
   assign data_wr_o      = s_q.data_wr;
   assign data_we_o      = s_q.data_we;
   assign ext_en_o       = s_q.ext_en;

endmodule

// ==== bench/ilo_decode_monitor.sv ====
/* port checker for the operand decoder.
   assumes a bind onto ilo_decode and a single clock domain. */
`timescale 1ns/1ps
module ilo_decode_monitor
(
   // clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // decode and memory side
   input wire logic        data_indexed_o,
   input wire logic        data_we_o,
   input wire logic        ext_en_o
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   req_answer_a: assert property ($rose(cyc_i && stb_i) |-> ##[1:2] ack_o)
      else $error("request not answered");
   dat_hold_a: assert property (!ack_o |-> $stable(dat_o))
      else $error("read data moved between answers");
   idx_needs_ext_a: assert property (data_indexed_o |-> ext_en_o)
      else $error("indexed address with extension off");
   ext_write_a: assert property ($changed(ext_en_o) |-> ack_o && $past(we_i && adr_i == 8'h00))
      else $error("enable changed without control write");
   we_pulse_a: assert property (data_we_o |=> !data_we_o)
      else $error("memory write longer than one cycle");
   we_cause_a: assert property (data_we_o |-> ack_o && $past(we_i && adr_i == 8'h18))
      else $error("memory write without execute");
endmodule

bind ilo_decode ilo_decode_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
   .data_indexed_o(data_indexed_o), .data_we_o(data_we_o), .ext_en_o(ext_en_o));

// ==== bench/tb_top.sv ====
/* self-checking bench for the operand decoder.
   assumes ilo_decode and its monitor are compiled before it. */
`timescale 1ns/1ps
module tb_top;
   // bench signals
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, data_indexed_o, data_we_o, ext_en_o, ws;
   logic [7:0]  adr_i, data_rd_i, data_wr_o, wd;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rdat;
   logic [11:0] data_addr_o, wa;
   int          miscompares, compares, cycles;

   // device under test
   ilo_decode i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .data_addr_o(data_addr_o), .data_indexed_o(data_indexed_o), .data_rd_i(data_rd_i),
      .data_wr_o(data_wr_o), .data_we_o(data_we_o), .ext_en_o(ext_en_o));

   // 250 mhz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // hang guard, well above the hundred or so cycles the tests need
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         miscompares++;
         end_sim;
      end
   end

   task end_sim;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // classic cycle; memory write strobe is captured at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      rdat = dat_o;
      ws = data_we_o;
      wd = data_wr_o;
      wa = data_addr_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // load an opcode and look at the decoded address
   task automatic dec(input logic [15:0] op, input logic [11:0] ea, input logic ei);
      wb(1'b1, 8'h10, {16'h0000, op});
      chk("addr", {20'h00000, ea}, {20'h00000, data_addr_o});
      chk("indexed", {31'h0, ei}, {31'h0, data_indexed_o});
   endtask

   task t_reset;
      chk("ext pin", 32'h0, {31'h0, ext_en_o});
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h0, rdat);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdat);
      $display("test reset done");
   endtask

   task t_legacy;
      wb(1'b1, 8'h08, 32'h3);
      dec(16'h2420, 12'h020, 1'b0);
      dec(16'h2520, 12'h320, 1'b0);
      dec(16'h2480, 12'hf80, 1'b0);
      $display("test legacy done");
   endtask

   task t_indexed;
      wb(1'b1, 8'h00, 32'h1);
      chk("ext pin", 32'h1, {31'h0, ext_en_o});
      wb(1'b1, 8'h04, 32'ha00);
      dec(16'h242c, 12'ha2c, 1'b1);
      dec(16'h245f, 12'ha5f, 1'b1);
      dec(16'h2460, 12'hf60, 1'b0);
      dec(16'h252c, 12'h32c, 1'b0);
      dec(16'h1c10, 12'ha10, 1'b1);
      wb(1'b1, 8'h04, 32'hfff);
      dec(16'h245f, 12'h05e, 1'b1);
      wb(1'b1, 8'h04, 32'h0);
      dec(16'h2410, 12'h010, 1'b1);
      wb(1'b1, 8'h04, 32'ha00);
      $display("test indexed done");
   endtask

   task t_add;
      wb(1'b1, 8'h0c, 32'h17);
      wb(1'b1, 8'h10, 32'h242c);
      data_rd_i <= 8'h20;
      wb(1'b1, 8'h18, 32'h0);
      wb(1'b0, 8'h0c, 32'h0);
      chk("acc", 32'h37, rdat);
      wb(1'b0, 8'h14, 32'h0);
      chk("flags", 32'h0, rdat);
      wb(1'b1, 8'h0c, 32'h80);
      wb(1'b1, 8'h10, 32'h262c);
      data_rd_i <= 8'h80;
      wb(1'b1, 8'h18, 32'h0);
      chk("mem we", 32'h1, {31'h0, ws});
      chk("mem data", 32'h0, {24'h0, wd});
      chk("mem addr", 32'ha2c, {20'h0, wa});
      wb(1'b0, 8'h14, 32'h0);
      chk("flags", 32'h0d, rdat);
      wb(1'b0, 8'h0c, 32'h0);
      chk("acc kept", 32'h80, rdat);
      $display("test add done");
   endtask

   task t_bset;
      wb(1'b1, 8'h14, 32'h15);
      wb(1'b1, 8'h10, 32'h8e0a);
      data_rd_i <= 8'h00;
      wb(1'b1, 8'h18, 32'h0);
      chk("mem data", 32'h80, {24'h0, wd});
      chk("mem addr", 32'ha0a, {20'h0, wa});
      wb(1'b0, 8'h14, 32'h0);
      chk("flags", 32'h15, rdat);
      wb(1'b0, 8'h18, 32'h0);
      chk("last addr", 32'h1a0a, rdat);
      $display("test bset done");
   endtask

   // main sequence
   initial
   begin
      {cyc_i, stb_i, we_i, adr_i, dat_i, data_rd_i} = '0;
      sel_i = 4'hf;
      rst_i = 1'b1;
      {miscompares, compares, cycles} = '0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_legacy;
      t_indexed;
      t_add;
      t_bset;
      end_sim;
   end
endmodule
